// ---- hdl/mpio_pkg.sv ----
package mpio_pkg;

  // register indices; byte address is four times the index
  localparam int IDX_W = 9;
  localparam logic [IDX_W-1:0] IDX_PB_DATA = 9'h006;
  localparam logic [IDX_W-1:0] IDX_PC_DATA = 9'h007;
  localparam logic [IDX_W-1:0] IDX_PD_DATA = 9'h008;
  localparam logic [IDX_W-1:0] IDX_INTC = 9'h00b;
  localparam logic [IDX_W-1:0] IDX_OPTION = 9'h081;
  localparam logic [IDX_W-1:0] IDX_PB_DIR = 9'h086;
  localparam logic [IDX_W-1:0] IDX_PC_DIR = 9'h087;
  localparam logic [IDX_W-1:0] IDX_PD_DIR = 9'h088;
  localparam logic [IDX_W-1:0] IDX_SEG_EN = 9'h10d;
  localparam logic [IDX_W-1:0] IDX_UNMAPPED = 9'h1ff;

  // reset values
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_PB_DIR = 8'hff;
  localparam logic [5:0] RST_PC_DIR = 6'h3f;
  localparam logic [7:0] RST_PD_DIR = 8'hff;
  localparam logic [7:0] RST_SEG_EN = 8'hff;
  localparam logic [7:0] RST_INTC = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'h00;

  // field positions
  localparam int OPT_PULLUP_N_BIT = 7;
  localparam int INTC_CHANGE_FLAG_BIT = 0;
  localparam int INTC_CHANGE_EN_BIT = 3;
  localparam int SEG_LOW_BIT = 0;
  localparam int SEG_HIGH_BIT = 7;
  localparam int PD_IO_PINS = 5;
  localparam int PB_EXT_INT_BIT = 0;
  localparam int PB_PROG_CLK_BIT = 6;
  localparam int PB_PROG_DATA_BIT = 7;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_WRITE = 4'h2,
    PH_RD_WAIT = 4'h4,
    PH_RD_DONE = 4'h8
  } mpio_phase_t;

  typedef struct packed {
    mpio_phase_t phase;
    logic [IDX_W-1:0] idx;
    logic [7:0] rdata;
    logic [7:0] pb_lat;
    logic [7:0] pb_dir;
    logic [7:0] opt;
    logic [5:0] pc_lat;
    logic [5:0] pc_dir;
    logic [7:0] pd_lat;
    logic [7:0] pd_dir;
    logic [7:0] seg_en;
    logic [7:0] intc;
    logic [3:0] cmp;
    logic [7:0] pb_s1;
    logic [7:0] pb_s2;
    logic [5:0] pc_s1;
    logic [5:0] pc_s2;
    logic [7:0] pd_s1;
    logic [7:0] pd_s2;
  } mpio_state_t;

endpackage

// ---- hdl/mpio_top.sv ----
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - port b direction bit set means input
// - option bit 7 low enables pull-ups on all input pins
// - pull-up off on any output pin
// - pull-ups disabled after power-on reset
// - only input pins 7..4 compared
// - mismatches ored into change flag bit 0
// - change event can wake from sleep
// - port b read or write refreshes latch
// - flag keeps setting while mismatch persists
// - pin 0 ext int, 6/7 programming
// - port c six pins, own directions
// - peripheral may override port c direction
// - port c pins carry peripheral functions
// - port c upper two bits read zero
// - port d pins 0-4 io, 5-7 input
// - port d direction only pins 0-4 digital
// - port d starts on lcd function
// - segment enable overrides direction bits
// - port d direction resets to all ones
module mpio_top
  import mpio_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [7:0] i_pb_pin,
  output logic [7:0] o_pb_out,
  output logic [7:0] o_pb_oe,
  output logic [7:0] o_pb_pullup,
  input wire logic i_prog_mode,
  input wire logic i_prog_data_out,
  input wire logic i_prog_data_oe,
  output logic o_ext_int,
  output logic o_prog_clock,
  output logic o_prog_data,
  output logic o_port_change,
  output logic o_wake,
  output logic [7:0] o_option,
  input wire logic [5:0] i_pc_pin,
  output logic [5:0] o_pc_out,
  output logic [5:0] o_pc_oe,
  input wire logic [5:0] i_pc_ovr_en,
  input wire logic [5:0] i_pc_ovr_dir,
  input wire logic [5:0] i_pc_periph_out,
  output logic [5:0] o_pc_in,
  input wire logic [7:0] i_pd_pin,
  output logic [7:0] o_pd_out,
  output logic [7:0] o_pd_oe,
  output logic [7:0] o_pd_lcd_sel
);

  ////////////////////////////////////////////////////////////////////////////////
  mpio_state_t st_r;
  mpio_state_t st_nxt;
  logic addr_take;
  logic [IDX_W-1:0] addr_idx;
  logic mismatch;
  logic [7:0] pb_dir_eff;
  logic [5:0] pc_dir_eff;
  logic [7:0] pd_oe_eff;

  function automatic logic [7:0] rd_mux(input mpio_state_t s, input logic [IDX_W-1:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_PB_DATA: v = s.pb_s2;
      IDX_PC_DATA: v = {2'b00, s.pc_s2};
      IDX_PD_DATA: v = s.pd_s2;
      IDX_INTC: v = s.intc;
      IDX_OPTION: v = s.opt;
      IDX_PB_DIR: v = s.pb_dir;
      IDX_PC_DIR: v = {2'b00, s.pc_dir};
      IDX_PD_DIR: v = s.pd_dir;
      IDX_SEG_EN: v = s.seg_en;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign addr_take = i_hsel && i_htrans[1] && i_hready;
  assign addr_idx = (i_haddr[31:11] == '0) ? i_haddr[10:2] : IDX_UNMAPPED;
  // one wait state on reads so a write just before is visible
  assign o_hreadyout = (st_r.phase != PH_RD_WAIT);
  assign o_hresp = 1'b0;
  assign o_hrdata = {24'h00_0000, st_r.rdata};

  ////////////////////////////////////////////////////////////////////////////////
  // change detection on upper pins that are inputs
  assign mismatch = |((st_r.pb_s2[7:4] ^ st_r.cmp) & pb_dir_eff[7:4]);

  always_comb begin
    st_nxt = st_r;
    st_nxt.pb_s1 = i_pb_pin;
    st_nxt.pb_s2 = st_r.pb_s1;
    st_nxt.pc_s1 = i_pc_pin;
    st_nxt.pc_s2 = st_r.pc_s1;
    st_nxt.pd_s1 = i_pd_pin;
    st_nxt.pd_s2 = st_r.pd_s1;
    if (st_r.phase == PH_WRITE) begin
      unique case (st_r.idx)
        IDX_PB_DATA: begin
          st_nxt.pb_lat = i_hwdata[7:0];
          st_nxt.cmp = st_r.pb_s2[7:4];
        end
        IDX_PC_DATA: st_nxt.pc_lat = i_hwdata[5:0];
        IDX_PD_DATA: st_nxt.pd_lat = i_hwdata[7:0];
        IDX_INTC: st_nxt.intc = i_hwdata[7:0];
        IDX_OPTION: st_nxt.opt = i_hwdata[7:0];
        IDX_PB_DIR: st_nxt.pb_dir = i_hwdata[7:0];
        IDX_PC_DIR: st_nxt.pc_dir = i_hwdata[5:0];
        IDX_PD_DIR: st_nxt.pd_dir = i_hwdata[7:0];
        IDX_SEG_EN: st_nxt.seg_en = i_hwdata[7:0];
        default: st_nxt.idx = st_r.idx;
      endcase
    end
    if (st_r.phase == PH_RD_WAIT) begin
      st_nxt.rdata = rd_mux(st_r, st_r.idx);
      if (st_r.idx == IDX_PB_DATA) begin
        st_nxt.cmp = st_r.pb_s2[7:4];
      end
    end
    unique case (st_r.phase)
      PH_RD_WAIT: st_nxt.phase = PH_RD_DONE;
      PH_IDLE, PH_WRITE, PH_RD_DONE: begin
        if (addr_take) begin
          st_nxt.idx = addr_idx;
          st_nxt.phase = i_hwrite ? PH_WRITE : PH_RD_WAIT;
        end else begin
          st_nxt.phase = PH_IDLE;
        end
      end
      default: st_nxt.phase = PH_IDLE;
    endcase
    // other resets: configuration back to defaults, data latches kept
    if (i_soft_rst) begin
      st_nxt.opt = RST_OPTION;
      st_nxt.pb_dir = RST_PB_DIR;
      st_nxt.pc_dir = RST_PC_DIR;
      st_nxt.pd_dir = RST_PD_DIR;
      st_nxt.seg_en = RST_SEG_EN;
      st_nxt.intc = RST_INTC;
    end
    // set wins over a software clear in the same cycle
    if (mismatch) begin
      st_nxt.intc[INTC_CHANGE_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{phase: PH_IDLE, idx: IDX_UNMAPPED, rdata: 8'h00, pb_lat: RST_LATCH,
                pb_dir: RST_PB_DIR, opt: RST_OPTION, pc_lat: RST_LATCH[5:0], pc_dir: RST_PC_DIR,
                pd_lat: RST_LATCH, pd_dir: RST_PD_DIR, seg_en: RST_SEG_EN, intc: RST_INTC,
                cmp: 4'h0, pb_s1: 8'h00, pb_s2: 8'h00, pc_s1: 6'h00, pc_s2: 6'h00,
                pd_s1: 8'h00, pd_s2: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // port b pins
  always_comb begin
    pb_dir_eff = st_r.pb_dir;
    if (i_prog_mode) begin
      pb_dir_eff[PB_PROG_CLK_BIT] = 1'b1;
      pb_dir_eff[PB_PROG_DATA_BIT] = ~i_prog_data_oe;
    end
  end

  always_comb begin
    o_pb_out = st_r.pb_lat;
    if (i_prog_mode) begin
      o_pb_out[PB_PROG_DATA_BIT] = i_prog_data_out;
    end
  end

  assign o_pb_oe = ~pb_dir_eff;
  assign o_pb_pullup = {8{~st_r.opt[OPT_PULLUP_N_BIT]}} & pb_dir_eff;
  assign o_ext_int = st_r.pb_s2[PB_EXT_INT_BIT];
  assign o_prog_clock = st_r.pb_s2[PB_PROG_CLK_BIT];
  assign o_prog_data = st_r.pb_s2[PB_PROG_DATA_BIT];
  assign o_port_change = st_r.intc[INTC_CHANGE_FLAG_BIT];
  assign o_wake = st_r.intc[INTC_CHANGE_FLAG_BIT] & st_r.intc[INTC_CHANGE_EN_BIT];
  assign o_option = st_r.opt;

  ////////////////////////////////////////////////////////////////////////////////
  // port c pins, peripherals may take over direction and data
  always_comb begin
    pc_dir_eff = st_r.pc_dir;
    o_pc_out = st_r.pc_lat;
    for (int i = 0; i < 6; i++) begin
      if (i_pc_ovr_en[i]) begin
        pc_dir_eff[i] = i_pc_ovr_dir[i];
        o_pc_out[i] = i_pc_periph_out[i];
      end
    end
  end

  assign o_pc_oe = ~pc_dir_eff;
  assign o_pc_in = st_r.pc_s2;

  ////////////////////////////////////////////////////////////////////////////////
  // port d pins, segment enable keeps pins on the lcd
  always_comb begin
    pd_oe_eff = 8'h00;
    o_pd_lcd_sel = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < PD_IO_PINS) begin
        o_pd_lcd_sel[i] = st_r.seg_en[SEG_LOW_BIT];
        pd_oe_eff[i] = ~st_r.seg_en[SEG_LOW_BIT] & ~st_r.pd_dir[i];
      end else begin
        o_pd_lcd_sel[i] = st_r.seg_en[SEG_HIGH_BIT];
      end
    end
  end

  assign o_pd_oe = pd_oe_eff;
  assign o_pd_out = st_r.pd_lat;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [1:0] boot_cnt_r;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      boot_cnt_r <= 2'h0;
    end else if (boot_cnt_r != 2'h3) begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_wr(logic [IDX_W-1:0] idx);
    st_r.phase == PH_WRITE && st_r.idx == idx && !i_soft_rst;
  endsequence

  sequence s_rd(logic [IDX_W-1:0] idx);
    st_r.phase == PH_RD_WAIT && st_r.idx == idx;
  endsequence

  property p_pb_dir_write;
    s_wr(IDX_PB_DIR) and (!i_prog_mode) ##0 1 |=> o_pb_oe[5:0] == ~$past(i_hwdata[5:0]);
  endproperty
  a_pb_dir_write: assert property (p_pb_dir_write) else $error("port b direction write not applied");

  property p_pullup_global;
    s_wr(IDX_OPTION) ##0 (!i_hwdata[OPT_PULLUP_N_BIT] && !i_prog_mode) ##1 !i_prog_mode
      |-> o_pb_pullup == $past(st_r.pb_dir);
  endproperty
  a_pullup_global: assert property (p_pullup_global) else $error("pull-ups not enabled");

  property p_pullup_out_off;
    (o_pb_pullup & o_pb_oe) == 8'h00;
  endproperty
  a_pullup_out_off: assert property (p_pullup_out_off) else $error("pull-up on output pin");

  property p_pullup_por;
    boot_cnt_r == 2'h0 |-> o_pb_pullup == 8'h00 && o_pd_lcd_sel == 8'hff && o_pd_oe == 8'h00;
  endproperty
  a_pullup_por: assert property (p_pullup_por) else $error("bad state after power-on");

  property p_mask_outputs;
    pb_dir_eff[7:4] == 4'h0 |-> !mismatch;
  endproperty
  a_mask_outputs: assert property (p_mask_outputs) else $error("output pin caused mismatch");

  property p_change_set;
    mismatch |=> o_port_change;
  endproperty
  a_change_set: assert property (p_change_set) else $error("change flag not set");

  property p_wake;
    mismatch && st_r.intc[INTC_CHANGE_EN_BIT] && !i_soft_rst && !(st_r.phase == PH_WRITE && st_r.idx == IDX_INTC)
      |=> o_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on change");

  property p_refresh;
    (s_rd(IDX_PB_DATA) or s_wr(IDX_PB_DATA)) |=> st_r.cmp == $past(st_r.pb_s2[7:4]);
  endproperty
  a_refresh: assert property (p_refresh) else $error("compare latch not refreshed");

  property p_flag_hold;
    s_wr(IDX_INTC) ##0 (!i_hwdata[INTC_CHANGE_FLAG_BIT] && mismatch) |=> o_port_change;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared during mismatch");

  property p_sync_delay;
    boot_cnt_r == 2'h3 |-> o_ext_int == $past(i_pb_pin[PB_EXT_INT_BIT], 2)
      && o_prog_data == $past(i_pb_pin[PB_PROG_DATA_BIT], 2) && o_pc_in == $past(i_pc_pin, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pin sync delay wrong");

  property p_pc_override;
    ((o_pc_oe ^ ~i_pc_ovr_dir) & i_pc_ovr_en) == 6'h00;
  endproperty
  a_pc_override: assert property (p_pc_override) else $error("override ignored");

  property p_pc_upper;
    (s_rd(IDX_PC_DATA) or s_rd(IDX_PC_DIR)) |=> o_hreadyout && o_hrdata[7:6] == 2'b00;
  endproperty
  a_pc_upper: assert property (p_pc_upper) else $error("port c upper bits not zero");

  property p_pd_segment;
    o_pd_oe[7:5] == 3'b000 && (o_pd_lcd_sel & o_pd_oe) == 8'h00;
  endproperty
  a_pd_segment: assert property (p_pd_segment) else $error("port d drive conflict");

  property p_pd_dir_reset;
    i_soft_rst |=> st_r.pd_dir == 8'hff;
  endproperty
  a_pd_dir_reset: assert property (p_pd_dir_reset) else $error("port d direction not reset");

endmodule

// ---- dv/mpio_pin_model.sv ----
`timescale 1ns/1ps
module mpio_pin_model #(
  parameter int W = 8
) (
  input wire logic i_clock,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_pullup,
  input wire logic [W-1:0] i_key_en,
  input wire logic [W-1:0] i_key_val,
  output logic [W-1:0] o_pin
);
  // a floating pin flips every cycle so no stale level passes for a good one
  logic [W-1:0] last_r = '0;
  always @(posedge i_clock) begin
    last_r <= o_pin;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      o_pin[i] = i_oe[i] ? i_out[i] : i_key_en[i] ? i_key_val[i] : i_pullup[i] ? 1'b1 : ~last_r[i];
    end
  end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import mpio_pkg::*;
  logic i_clock = 0, i_rst = 1, i_soft_rst = 0, i_hsel = 0, i_hwrite = 0, i_hready;
  logic [31:0] i_haddr = '0, i_hwdata = '0, o_hrdata, rd_q;
  logic [1:0] i_htrans = '0;
  logic [2:0] i_hsize = 3'b010;
  logic o_hreadyout, o_hresp, o_ext_int, o_prog_clock, o_prog_data, o_port_change, o_wake;
  logic i_prog_mode = 0, i_prog_data_out = 0, i_prog_data_oe = 0;
  logic [7:0] i_pb_pin, o_pb_out, o_pb_oe, o_pb_pullup, o_option, i_pd_pin, o_pd_out, o_pd_oe, o_pd_lcd_sel;
  logic [5:0] i_pc_pin, o_pc_out, o_pc_oe, o_pc_in;
  logic [5:0] i_pc_ovr_en = '0, i_pc_ovr_dir = '0, i_pc_periph_out = '0;
  logic [7:0] pb_key_en = '0;
  logic [5:0] pc_key_en = 6'h3f, pc_key_val = 6'h15;
  logic [7:0] pd_key_en = 8'hff, pd_key_val = 8'h42;
  int errors = 0;
  int comparisons = 0;

  always #2.5 i_clock = ~i_clock;
  assign i_hready = o_hreadyout;

  mpio_top i_dut (.*);
  mpio_pin_model #(.W(8)) i_pb_pins (.i_clock(i_clock), .i_oe(o_pb_oe), .i_out(o_pb_out),
    .i_pullup(o_pb_pullup), .i_key_en(pb_key_en), .i_key_val(8'h00), .o_pin(i_pb_pin));
  mpio_pin_model #(.W(6)) i_pc_pins (.i_clock(i_clock), .i_oe(o_pc_oe), .i_out(o_pc_out),
    .i_pullup(6'h00), .i_key_en(pc_key_en), .i_key_val(pc_key_val), .o_pin(i_pc_pin));
  mpio_pin_model #(.W(8)) i_pd_pins (.i_clock(i_clock), .i_oe(o_pd_oe), .i_out(o_pd_out),
    .i_pullup(8'h00), .i_key_en(pd_key_en), .i_key_val(pd_key_val), .o_pin(i_pd_pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // ready and read data sampled at the rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge i_clock);
    while (o_hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(posedge i_clock);
    end
    if (n >= 20) begin
      errors++;
      $display("MISMATCH t=%0t bus hang", $time);
      end_of_test();
    end else begin
      rd_q = o_hrdata;
    end
  endtask

  task automatic bus(input logic [IDX_W-1:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    i_haddr <= {21'h0, idx, 2'b00};
    wait_rdy();
    i_htrans <= 2'b00;
    i_hwdata <= {24'h0, wd};
    wait_rdy();
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(rd_q[7:0], exp);
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    chk(o_pb_pullup, 8'h00);
    chk(o_pb_oe, 8'h00);
    chk(o_pd_lcd_sel, 8'hff);
    rd(IDX_OPTION, 8'hff);
    chk_flag(o_hresp, 1'b0);
    rd(IDX_PB_DIR, 8'hff);
    rd(IDX_PC_DIR, 8'h3f);
    rd(IDX_PD_DIR, 8'hff);
    wr(IDX_UNMAPPED, 8'h55);
    rd(IDX_UNMAPPED, 8'h00);
    // direction and pull-ups
    wr(IDX_PB_DIR, 8'hcf);
    wr(IDX_PB_DATA, 8'ha5);
    look(0);
    chk(o_pb_oe, 8'h30);
    chk(o_pb_out, 8'ha5);
    chk(o_pb_pullup, 8'h00);
    wr(IDX_OPTION, 8'h7f);
    look(3);
    chk(o_pb_pullup, 8'hcf);
    rd(IDX_PB_DATA, 8'hef);
    // change detection
    wr(IDX_PB_DIR, 8'hff);
    look(3);
    rd(IDX_PB_DATA, 8'hff);
    wr(IDX_INTC, 8'h08);
    look(0);
    chk_flag(o_port_change, 1'b0);
    @(posedge i_clock);
    pb_key_en <= 8'h03;
    look(1);
    chk_flag(o_ext_int, 1'b1);
    look(3);
    chk_flag(o_ext_int, 1'b0);
    chk_flag(o_port_change, 1'b0);
    @(posedge i_clock);
    pb_key_en <= 8'h23;
    look(1);
    chk_flag(o_port_change, 1'b0);
    look(3);
    chk_flag(o_port_change, 1'b1);
    wr(IDX_INTC, 8'h08);
    look(0);
    chk_flag(o_port_change, 1'b1);
    chk_flag(o_wake, 1'b1);
    rd(IDX_PB_DATA, 8'hdc);
    wr(IDX_INTC, 8'h08);
    look(0);
    chk_flag(o_port_change, 1'b0);
    chk_flag(o_wake, 1'b0);
    @(posedge i_clock);
    pb_key_en <= 8'ha3;
    look(4);
    chk_flag(o_port_change, 1'b1);
    wr(IDX_PB_DATA, 8'h00);
    wr(IDX_INTC, 8'h08);
    look(0);
    chk_flag(o_port_change, 1'b0);
    @(posedge i_clock);
    pb_key_en <= 8'h03;
    look(3);
    rd(IDX_PB_DATA, 8'hfc);
    wr(IDX_INTC, 8'h08);
    wr(IDX_PB_DIR, 8'hef);
    look(4);
    chk_flag(o_port_change, 1'b0);
    chk(o_pb_pullup, 8'hef);
    // programming mode on the upper pins
    @(posedge i_clock);
    pb_key_en <= 8'h43;
    i_prog_mode <= 1'b1;
    i_prog_data_oe <= 1'b1;
    i_prog_data_out <= 1'b1;
    look(3);
    chk(o_pb_oe, 8'h90);
    chk_flag(o_pb_out[7], 1'b1);
    chk_flag(o_prog_clock, 1'b0);
    chk_flag(o_prog_data, 1'b1);
    @(posedge i_clock);
    i_prog_mode <= 1'b0;
    // six-pin port and peripheral takeover
    wr(IDX_PC_DIR, 8'h00);
    wr(IDX_PC_DATA, 8'hea);
    look(0);
    chk({2'b00, o_pc_oe}, 8'h3f);
    chk({2'b00, o_pc_out}, 8'h2a);
    rd(IDX_PC_DIR, 8'h00);
    wr(IDX_PC_DIR, 8'hff);
    rd(IDX_PC_DIR, 8'h3f);
    rd(IDX_PC_DATA, 8'h15);
    chk({2'b00, o_pc_in}, 8'h15);
    @(posedge i_clock);
    pc_key_val <= 6'h2a;
    look(3);
    chk({2'b00, o_pc_in}, 8'h2a);
    @(posedge i_clock);
    i_pc_ovr_en <= 6'h06;
    i_pc_ovr_dir <= 6'h02;
    i_pc_periph_out <= 6'h3f;
    look(1);
    chk({2'b00, o_pc_oe}, 8'h04);
    chk({2'b00, o_pc_out & 6'h04}, 8'h04);
    wr(IDX_PC_DIR, 8'h00);
    look(0);
    chk({2'b00, o_pc_oe}, 8'h3d);
    // segment port
    wr(IDX_PD_DIR, 8'h00);
    look(0);
    chk(o_pd_oe, 8'h00);
    wr(IDX_SEG_EN, 8'hfe);
    look(0);
    chk(o_pd_lcd_sel, 8'he0);
    chk(o_pd_oe, 8'h1f);
    wr(IDX_SEG_EN, 8'h00);
    wr(IDX_PD_DIR, 8'h07);
    wr(IDX_PD_DATA, 8'hff);
    look(2);
    chk(o_pd_lcd_sel, 8'h00);
    chk(o_pd_oe, 8'h18);
    rd(IDX_PD_DATA, 8'h5a);
    // other reset
    @(posedge i_clock);
    i_soft_rst <= 1'b1;
    @(posedge i_clock);
    i_soft_rst <= 1'b0;
    look(0);
    chk(o_option, 8'hff);
    chk(o_pb_pullup, 8'h00);
    chk(o_pd_lcd_sel, 8'hff);
    chk(o_pd_out, 8'hff);
    rd(IDX_PD_DIR, 8'hff);
    end_of_test();
  end
endmodule
